// *** verilog/dpc_top.sv ***
// serial programming, register file, dividers and power-down control
// assumes vco ticks arrive as one-cycle pulses on clock_i; pins are async
`timescale 1ns/10ps
`default_nettype none
`include "dpc_regs.svh"
module dpc_top import dpc_pkg::*; #(
   parameter int unsigned WDOG_CYCLES = `DPC_WDOG_CYCLES
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_b_i,
   // pins
   input wire logic ser_clk_i,
   input wire logic ser_data_i,
   input wire logic power_down_pin_i,
   // video register choice and vco ticks
   input wire logic [1:0] video_reg_sel_i,
   input wire logic video_vco_tick_i,
   input wire logic memory_vco_tick_i,
   // clock outputs
   output logic video_clock_out_o,
   output logic memory_clock_out_o,
   output logic video_vco_enable_o,
   output logic memory_vco_enable_o,
   output logic ref_osc_enable_o,
   // pll settings
   output logic [7:0] video_fb_div_o,
   output logic [7:0] video_ref_div_o,
   output logic [2:0] video_prescale_o,
   output logic [2:0] video_post_sel_o,
   output logic [7:0] memory_fb_div_o,
   output logic [7:0] memory_ref_div_o,
   output logic [2:0] memory_prescale_o,
   output logic [2:0] memory_post_sel_o,
   // status
   output logic load_pulse_o,
   output logic prog_error_o,
   output logic unlocked_o,
   output logic [1:0] pd_mode_o,
   output logic [5:0] pd_divisor_o
);
   default clocking dpc_cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   if (WDOG_CYCLES < 2 || WDOG_CYCLES > 32'h7FFFFFFF) begin : g_chk
      $error("WDOG_CYCLES out of range");
   end

   function automatic logic [6:0] div_lim(input logic [2:0] sel);
      div_lim = 7'((8'h01 << sel) - 8'h01);
   endfunction : div_lim

   // three-stage pin synchronisers: bit0 clk, bit1 data, bit2 pd
   logic [2:0] sy1_ff, sy2_ff, sy3_ff, flt_ff;
   wire [2:0] sy_eq = ~(sy2_ff ^ sy3_ff);
   wire [2:0] nxt_flt = (sy2_ff & sy_eq) | (flt_ff & ~sy_eq);
   always_ff @(posedge clock_i) begin
      sy1_ff <= {power_down_pin_i, ser_data_i, ser_clk_i};
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
      if (!rst_b_i) flt_ff <= 3'h7;
      else flt_ff <= nxt_flt;
   end
   wire clk_rise = nxt_flt[0] & ~flt_ff[0];
   wire clk_fall = ~nxt_flt[0] & flt_ff[0];
   wire din = nxt_flt[1];
   wire any_trans = nxt_flt[1:0] != flt_ff[1:0];

   // watchdog; idles saturated so a quiet link stays relocked
   logic [31:0] wdog_ff;
   wire [31:0] wdog_lim = 32'(WDOG_CYCLES - 1);
   wire wdog_exp = (wdog_ff == wdog_lim) & ~any_trans;
   always_ff @(posedge clock_i) begin
      if (!rst_b_i || any_trans) wdog_ff <= 32'h00000000;
      else if (wdog_ff != wdog_lim) wdog_ff <= wdog_ff + 32'h00000001;
   end

   // serial state machine
   dpc_state_e state_ff, nxt_state;
   logic [2:0] ones_ff, nxt_ones;
   logic [4:0] cnt_ff, nxt_cnt;
   logic [23:0] sr_ff, nxt_sr;
   logic fall_ff;
   logic load, err;
   logic [1:0] pd_ff;
   wire pd_active = pd_ff != PD_NONE;
   always_comb begin
      nxt_state = state_ff;
      nxt_ones = ones_ff;
      nxt_cnt = cnt_ff;
      nxt_sr = sr_ff;
      load = 1'b0;
      err = 1'b0;
      if (pd_active || wdog_exp) begin
         nxt_state = ST_LOCK;
         nxt_ones = 3'h0;
         nxt_sr = 24'h000000;
      end else if (clk_rise) begin
         case (state_ff)
            ST_LOCK: begin
               if (din) begin
                  if (ones_ff != `DPC_UNLOCK_ONES) nxt_ones = ones_ff + 3'h1;
               end else if (ones_ff == `DPC_UNLOCK_ONES) begin
                  nxt_state = ST_SHIFT; // low edge is the start bit
                  nxt_cnt = 5'h00;
                  nxt_ones = 3'h0;
               end else begin
                  nxt_ones = 3'h0;
               end
            end
            ST_SHIFT: begin
               if (din != fall_ff) begin
                  nxt_sr = {sr_ff[22:0], din};
                  nxt_cnt = cnt_ff + 5'h01;
                  if (cnt_ff == `DPC_SR_LAST) nxt_state = ST_FULL;
               end else begin
                  err = 1'b1; // also an early stop
                  nxt_state = ST_LOCK;
                  nxt_sr = 24'h000000;
               end
            end
            ST_FULL: begin
               load = din & fall_ff;
               err = ~load;
               nxt_state = ST_LOCK;
               nxt_sr = 24'h000000;
            end
            default: nxt_state = ST_LOCK;
         endcase
      end
   end
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         state_ff <= ST_LOCK;
         ones_ff <= 3'h0;
         cnt_ff <= 5'h00;
         sr_ff <= 24'h000000;
         fall_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         ones_ff <= nxt_ones;
         cnt_ff <= nxt_cnt;
         sr_ff <= nxt_sr;
         if (clk_fall) fall_ff <= din;
      end
   end

   // register file, written only by a good stop bit
   wire [2:0] wr_addr = sr_ff[2:0];
   wire [20:0] wr_data = sr_ff[23:3];
   logic [20:0] vreg_ff [3];
   logic [20:0] mreg_ff, ctl_ff;
   logic [3:0] pwr_ff;
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         vreg_ff <= '{default: `DPC_VCO_RST};
         mreg_ff <= `DPC_VCO_RST;
         ctl_ff <= `DPC_CTL_RST;
         pwr_ff <= `DPC_PD_DIV_RST;
      end else if (load) begin
         if (wr_addr < `DPC_ADDR_MEM) vreg_ff[wr_addr[1:0]] <= wr_data;
         if (wr_addr == `DPC_ADDR_MEM) mreg_ff <= wr_data;
         if (wr_addr == `DPC_ADDR_CTRL) ctl_ff <= wr_data;
         if (wr_addr == `DPC_ADDR_PD_DIV && wr_data[3:0] != 4'h0) begin
            pwr_ff <= wr_data[3:0];
         end
      end
   end

   // field decode; select value 3 falls back to register 2
   wire [1:0] vsel = (video_reg_sel_i == 2'h3) ? 2'h2 : video_reg_sel_i;
   wire [20:0] vword = vreg_ff[vsel];
   wire [3:0] vidx = vword[`DPC_IDX_HI:`DPC_IDX_LO];
   wire vid_off = vidx == `DPC_IDX_VID_OFF;
   wire vid_mux = vidx == `DPC_IDX_VID_MUX;
   wire [7:0] v_n = {1'b0, vword[`DPC_N_HI:`DPC_N_LO]} + `DPC_N_ADD;
   wire [7:0] v_m = {1'b0, vword[`DPC_M_HI:`DPC_M_LO]} + `DPC_M_ADD;
   wire [7:0] m_n = {1'b0, mreg_ff[`DPC_N_HI:`DPC_N_LO]} + `DPC_N_ADD;
   wire [7:0] m_m = {1'b0, mreg_ff[`DPC_M_HI:`DPC_M_LO]} + `DPC_M_ADD;
   wire [2:0] v_r = vword[`DPC_R_HI:`DPC_R_LO];
   wire [2:0] m_r = mreg_ff[`DPC_R_HI:`DPC_R_LO];
   wire v_ps = ctl_ff[vsel];
   wire m_ps = ctl_ff[`DPC_CTL_PS_MEM];
   wire [5:0] pd_div = `DPC_PD_DIV_BASE - {1'b0, pwr_ff, 1'b0};

   // power-down mode is chosen at the pin's fall and held until it rises
   always_ff @(posedge clock_i) begin
      if (!rst_b_i || flt_ff[2]) pd_ff <= PD_NONE;
      else if (pd_ff == PD_NONE) begin
         pd_ff <= ctl_ff[`DPC_CTL_PD2] ? PD_MODE2 : PD_MODE1;
      end
   end

   // post dividers on vco ticks; standby clock from the reference
   logic [6:0] vcnt_ff, mcnt_ff;
   logic [4:0] sb_cnt_ff;
   logic sb_clk_ff;
   wire v_tick = vid_mux ? memory_vco_tick_i : video_vco_tick_i;
   wire v_hit = v_tick && vcnt_ff == div_lim(v_r);
   wire m_hit = memory_vco_tick_i && mcnt_ff == div_lim(m_r);
   wire [4:0] sb_half = pd_div[5:1] - 5'h01;
   always_ff @(posedge clock_i) begin
      if (!rst_b_i || pd_active) begin
         vcnt_ff <= 7'h00;
         mcnt_ff <= 7'h00;
      end else begin
         if (v_tick) vcnt_ff <= v_hit ? 7'h00 : vcnt_ff + 7'h01;
         if (memory_vco_tick_i) mcnt_ff <= m_hit ? 7'h00 : mcnt_ff + 7'h01;
      end
      if (!rst_b_i || pd_ff != PD_MODE1) begin
         sb_cnt_ff <= 5'h00;
         sb_clk_ff <= 1'b0;
      end else if (sb_cnt_ff == sb_half) begin
         sb_cnt_ff <= 5'h00;
         sb_clk_ff <= ~sb_clk_ff;
      end else begin
         sb_cnt_ff <= sb_cnt_ff + 5'h01;
      end
   end

   // registered outputs
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         video_clock_out_o <= 1'b0;
         memory_clock_out_o <= 1'b0;
         video_vco_enable_o <= 1'b0;
         memory_vco_enable_o <= 1'b0;
         ref_osc_enable_o <= 1'b1;
         video_fb_div_o <= 8'h00;
         video_ref_div_o <= 8'h00;
         video_prescale_o <= `DPC_PRESCALE_LO;
         video_post_sel_o <= 3'h0;
         memory_fb_div_o <= 8'h00;
         memory_ref_div_o <= 8'h00;
         memory_prescale_o <= `DPC_PRESCALE_LO;
         memory_post_sel_o <= 3'h0;
         load_pulse_o <= 1'b0;
         prog_error_o <= 1'b0;
      end else begin
         // mode one holds video high, mode two silences everything
         video_clock_out_o <= (pd_ff == PD_MODE1) |
            (~pd_active & ~vid_off & v_hit);
         memory_clock_out_o <= (pd_ff == PD_MODE1) ? sb_clk_ff :
            (~pd_active & m_hit);
         video_vco_enable_o <= ~pd_active & ~vid_off & ~vid_mux;
         memory_vco_enable_o <= ~pd_active;
         ref_osc_enable_o <= pd_ff != PD_MODE2;
         video_fb_div_o <= v_n;
         video_ref_div_o <= v_m;
         video_prescale_o <= v_ps ? `DPC_PRESCALE_HI : `DPC_PRESCALE_LO;
         video_post_sel_o <= v_r;
         memory_fb_div_o <= m_n;
         memory_ref_div_o <= m_m;
         memory_prescale_o <= m_ps ? `DPC_PRESCALE_HI : `DPC_PRESCALE_LO;
         memory_post_sel_o <= m_r;
         load_pulse_o <= load;
         prog_error_o <= err;
      end
   end
   assign unlocked_o = state_ff != ST_LOCK;
   assign pd_mode_o = pd_ff;
   assign pd_divisor_o = pd_div;

   // checks
   AST_LOAD_FULL: assert property (load |->
      state_ff == ST_FULL && cnt_ff == 5'h18)
      else $error("load without 24 bits");
   AST_OVERFLOW: assert property (state_ff == ST_FULL && clk_rise &&
      !pd_active && !wdog_exp && din != fall_ff |=>
      prog_error_o && !load_pulse_o)
      else $error("overflow not flagged");
   AST_REARM: assert property ((load || err) |=>
      state_ff == ST_LOCK && ones_ff == 3'h0)
      else $error("no rearm after word");
   // the first edge after release still shows reset values, so skip it
   AST_EFF_DIV: assert property ($past(rst_b_i) |->
      video_fb_div_o - 8'h03 == {1'b0, $past(vword[`DPC_N_HI:`DPC_N_LO])}
      && memory_ref_div_o - 8'h02 ==
      {1'b0, $past(mreg_ff[`DPC_M_HI:`DPC_M_LO])})
      else $error("effective divide wrong");
   AST_VID_OFF: assert property ((vid_off && !pd_active) |=>
      !video_clock_out_o && memory_vco_enable_o)
      else $error("video not off");
   AST_PD1_HIGH: assert property (pd_ff == PD_MODE1 |=>
      video_clock_out_o && !video_vco_enable_o)
      else $error("mode one video not high");
   AST_PD2_QUIET: assert property (pd_ff == PD_MODE2 [*2] |->
      !video_clock_out_o && !memory_clock_out_o && !ref_osc_enable_o)
      else $error("mode two outputs active");
   AST_PD_DIV: assert property (pwr_ff != 4'h0 &&
      pd_div + {1'b0, pwr_ff, 1'b0} == 6'h22)
      else $error("power-down divisor wrong");
   AST_PD_EXIT: assert property (flt_ff[2] |=> pd_ff == PD_NONE)
      else $error("power-down not left");
   AST_WDOG: assert property (wdog_exp |=>
      state_ff == ST_LOCK && sr_ff == 24'h000000)
      else $error("watchdog did not relock");
endmodule : dpc_top
`default_nettype wire

// *** include/dpc_regs.svh ***
// constants for the dual pll program control block
// assumes a 250 MHz core clock that also stands for the reference clock
// Operation
// - serial word held in 24-bit shift register
// - stop bit loads word into addressed register; code skips a power-down word whose value is zero
// - extra bits after full register: discard, error
// - handled word rearms unlock; faulty word errors
// - word holds index, feedback, divider, reference fields
// - first index bit MSB, last reference bit LSB
// - feedback divide N'+3, reference divide M'+2
// - output divide by two to divider select
// - index 1110 turns video clock off only
// - index 1111 feeds video from memory vco
// - low pin, bit clear: vcos off, video high
// - mode one: memory clock is reference over divisor
// - power-down divisor is 34 minus twice value
// - mode two stops outputs, oscillator, keeps registers
// - pin high leaves either power-down mode
// - five high-data rising edges, then low, unlock
// - start, 21 data, 3 address, stop bit
// - complement of each bit at prior falling edge; code checks only the 24 word bits, stop bit high at both edges
// - watchdog restarts on transitions, expiry relocks, discards
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH
`define DPC_SR_BITS 24
`define DPC_SR_LAST 5'h17
`define DPC_UNLOCK_ONES 3'h5
`define DPC_IDX_HI 20
`define DPC_IDX_LO 17
`define DPC_N_HI 16
`define DPC_N_LO 10
`define DPC_R_HI 9
`define DPC_R_LO 7
`define DPC_M_HI 6
`define DPC_M_LO 0
`define DPC_N_ADD 8'h03
`define DPC_M_ADD 8'h02
`define DPC_IDX_VID_OFF 4'hE
`define DPC_IDX_VID_MUX 4'hF
`define DPC_ADDR_MEM 3'h3
`define DPC_ADDR_PD_DIV 3'h4
`define DPC_ADDR_CTRL 3'h6
`define DPC_CTL_PS_MEM 3
`define DPC_CTL_PD2 4
`define DPC_CTL_RST 21'h000000
`define DPC_VCO_RST 21'h000000
`define DPC_PD_DIV_RST 4'h8
`define DPC_PD_DIV_BASE 6'h22
`define DPC_PRESCALE_LO 3'h2
`define DPC_PRESCALE_HI 3'h4
`define DPC_CLK_MHZ 250
`define DPC_WDOG_MS 2
`define DPC_WDOG_CYCLES (`DPC_WDOG_MS * `DPC_CLK_MHZ * 1000)
`endif

// *** include/dpc_pkg.sv ***
// types for the dual pll program control block
// assumes dpc_regs.svh is compiled alongside
package dpc_pkg;
   typedef enum logic [1:0] {
      ST_LOCK = 2'b00,
      ST_SHIFT = 2'b01,
      ST_FULL = 2'b11
   } dpc_state_e;
   typedef enum logic [1:0] {
      PD_NONE = 2'b00,
      PD_MODE1 = 2'b01,
      PD_MODE2 = 2'b11
   } dpc_pd_e;
endpackage : dpc_pkg

// *** verification/dpc_host_model.sv ***
// host model: drives the serial clock and data pins of the block
// assumes the bench calls its tasks just after a rising clock_i edge
`timescale 1ns/10ps
`default_nettype none
module dpc_host_model (
   // clock
   input wire logic clock_i,
   // serial pins
   output logic ser_clk_o,
   output logic ser_data_o
);
   // serial clock stands still low between frames, data rests high
   initial begin
      ser_clk_o = 1'b0;
      ser_data_o = 1'b1;
   end
   // data settles before the clock moves; 5 cycles beats the pin filter
   task automatic pin(input logic c, input logic d);
      ser_data_o <= d;
      repeat (5) @(posedge clock_i);
      ser_clk_o <= c;
      repeat (5) @(posedge clock_i);
   endtask : pin
   task automatic unlock();
      repeat (5) begin
         pin(1'b0, 1'b1);
         pin(1'b1, 1'b1);
      end
      pin(1'b0, 1'b0);
      pin(1'b1, 1'b0);
   endtask : unlock
   // fault 0 none, 1 wrong complement on one bit, 2 one bit too many
   task automatic word(input logic [23:0] w, input int fault);
      int i;
      unlock();
      for (i = 23; i >= 0; i--) begin
         pin(1'b0, ~w[i] ^ (fault == 1 && i == 12));
         pin(1'b1, w[i]);
      end
      if (fault == 2) begin
         pin(1'b0, 1'b1);
         pin(1'b1, 1'b0);
      end
      pin(1'b0, 1'b1);
      pin(1'b1, 1'b1);
      pin(1'b0, 1'b1);
   endtask : word
endmodule : dpc_host_model
`default_nettype wire

// *** verification/tb_dual_pll_program_control.sv ***
// testbench: programs words through the host model and checks outputs
// assumes the design top dpc_top and the host model dpc_host_model
`timescale 1ns/10ps
`default_nettype none
module tb_dual_pll_program_control;
   logic clock_i, rst_b_i, pd_pin, vtick, mtick, sck, sda;
   logic [1:0] sel, tcnt;
   logic video_clock_out, mclk, ven, men, ren, ld, perr, unl;
   logic [7:0] vfb, vref, mfb, mref;
   logic [2:0] vps, vpost, mps, mpost;
   logic [1:0] pdm;
   logic [5:0] pdd;
   int errors, tests_run, loads, perrs, v, m;
   dpc_top #(.WDOG_CYCLES(64)) dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .ser_clk_i(sck), .ser_data_i(sda), .power_down_pin_i(pd_pin),
      .video_reg_sel_i(sel), .video_vco_tick_i(vtick),
      .memory_vco_tick_i(mtick), .video_clock_out_o(video_clock_out),
      .memory_clock_out_o(mclk), .video_vco_enable_o(ven),
      .memory_vco_enable_o(men), .ref_osc_enable_o(ren),
      .video_fb_div_o(vfb), .video_ref_div_o(vref), .video_prescale_o(vps),
      .video_post_sel_o(vpost), .memory_fb_div_o(mfb),
      .memory_ref_div_o(mref), .memory_prescale_o(mps),
      .memory_post_sel_o(mpost), .load_pulse_o(ld), .prog_error_o(perr),
      .unlocked_o(unl), .pd_mode_o(pdm), .pd_divisor_o(pdd));
   dpc_host_model host_u (.clock_i(clock_i), .ser_clk_o(sck),
      .ser_data_o(sda));
   initial begin
      clock_i = 1'b0;
      tcnt = 2'h0;
      vtick = 1'b0;
      mtick = 1'b0;
      loads = 0;
      perrs = 0;
   end
   always #2 clock_i = ~clock_i;
   // video vco ticks twice as often as memory, so a mux shows up in counts
   always @(posedge clock_i) begin
      tcnt <= tcnt + 2'h1;
      vtick <= tcnt[0];
      mtick <= (tcnt == 2'h3);
      if (ld === 1'b1) loads <= loads + 1;
      if (perr === 1'b1) perrs <= perrs + 1;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic prog(input logic [23:0] w, input int fault);
      host_u.word(w, fault);
      repeat (4) @(posedge clock_i);
   endtask : prog
   // video high cycles and memory rising edges over 64 cycles; rises
   // show the standby divisor, a duty count of a square wave would not
   task automatic count();
      logic mp;
      v = 0;
      m = 0;
      mp = mclk;
      repeat (64) begin
         @(posedge clock_i);
         #1;
         v += int'(video_clock_out === 1'b1);
         m += int'(mclk === 1'b1 && mp !== 1'b1);
         mp = mclk;
      end
      // hand back on an edge so later stimulus stays edge aligned
      @(posedge clock_i);
   endtask : count
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out
   initial begin
      errors = 0;
      tests_run = 0;
      rst_b_i = 1'b0;
      pd_pin = 1'b1;
      sel = 2'h0;
      repeat (8) @(posedge clock_i);
      rst_b_i <= 1'b1;
      repeat (6) @(posedge clock_i);
      check(pdd, 8'h12);
      check(vfb, 8'h03);
      check(vref, 8'h02);
      check(vps, 8'h02);
      prog({4'h0, 7'h45, 3'h5, 7'h12, 3'h0}, 0);
      check(loads, 8'h01);
      check(vfb, 8'h48);
      check(vref, 8'h14);
      check(vpost, 8'h05);
      check(unl, 8'h00);
      // a tick every 2 cycles over divide 32: one pulse per 64 cycles
      count();
      check(v, 8'h01);
      prog({4'h0, 7'h7F, 3'h7, 7'h7F, 3'h3}, 0);
      check(mfb, 8'h82);
      check(mref, 8'h81);
      check(mpost, 8'h07);
      check(vfb, 8'h48);
      prog({21'h000009, 3'h6}, 0);
      check(vps, 8'h04);
      check(mps, 8'h04);
      prog({4'h0, 7'h01, 3'h0, 7'h01, 3'h0}, 1);
      check(perrs, 8'h01);
      check(loads, 8'h03);
      prog({4'h0, 7'h01, 3'h0, 7'h01, 3'h0}, 2);
      check(perrs, 8'h02);
      check(vfb, 8'h48);
      prog({4'hE, 7'h10, 3'h0, 7'h10, 3'h1}, 0);
      sel <= 2'h1;
      repeat (4) @(posedge clock_i);
      check(ven, 8'h00);
      check(men, 8'h01);
      count();
      check(v, 8'h00);
      prog({4'hF, 7'h10, 3'h0, 7'h10, 3'h2}, 0);
      sel <= 2'h2;
      count();
      check(v >= 15 && v <= 17, 8'h01);
      // select value 3 reads register 2
      sel <= 2'h3;
      repeat (4) @(posedge clock_i);
      check(vfb, 8'h13);
      sel <= 2'h0;
      prog({17'h00000, 4'h1, 3'h4}, 0);
      check(pdd, 8'h20);
      prog({17'h00000, 4'h0, 3'h4}, 0);
      check(pdd, 8'h20);
      prog({17'h00000, 4'hF, 3'h4}, 0);
      check(pdd, 8'h04);
      pd_pin <= 1'b0;
      repeat (8) @(posedge clock_i);
      check(pdm, 8'h01);
      check(video_clock_out, 8'h01);
      check(men, 8'h00);
      count();
      check(m >= 15 && m <= 17, 8'h01);
      pd_pin <= 1'b1;
      repeat (8) @(posedge clock_i);
      check(pdm, 8'h00);
      check(men, 8'h01);
      prog({21'h000019, 3'h6}, 0);
      pd_pin <= 1'b0;
      repeat (8) @(posedge clock_i);
      check(pdm, 8'h03);
      check(ren, 8'h00);
      count();
      check(m + v, 8'h00);
      pd_pin <= 1'b1;
      repeat (8) @(posedge clock_i);
      check(pdm, 8'h00);
      check(pdd, 8'h04);
      check(ren, 8'h01);
      host_u.unlock();
      repeat (3) @(posedge clock_i);
      check(unl, 8'h01);
      repeat (80) @(posedge clock_i);
      check(unl, 8'h00);
      check(perrs, 8'h02);
      close_out();
   end
endmodule : tb_dual_pll_program_control
`default_nettype wire
